// ==== src/afr_pkg.sv ====
package afr_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] REMAP_CFG0_OFS = 8'h04;
	localparam logic [31:0] REMAP_CFG0_RST = 32'h0000_0000;
	localparam int USB_SOF_BIT = 29;
	localparam int SPI_ROUTE_BIT = 28;
	localparam int DBG_CFG_LSB = 24;
	localparam int DBG_CFG_W = 3;
	localparam int CAN_ROUTE_BIT = 22;
	localparam int ADC_TRIG_BIT = 20;
	localparam logic [2:0] DBG_FULL = 3'h0;
	localparam logic [2:0] DBG_NO_JRST = 3'h1;
	localparam logic [2:0] DBG_SW_ONLY = 3'h2;
	localparam logic [2:0] DBG_NONE = 3'h4;
	localparam logic [2:0] DBG_EN_RST = 3'h7;
	typedef enum logic [1:0] {
		AFR_DBG_FULL = 2'h0,
		AFR_DBG_NO_JRST = 2'h1,
		AFR_DBG_SW_ONLY = 2'h3,
		AFR_DBG_NONE = 2'h2
	} afr_dbg_e;
endpackage

// ==== src/afr_remap_cfg.sv ====
`timescale 1ns/1ps
module afr_remap_cfg #(
	parameter int RST_STAGES = 2
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic [afr_pkg::ADDR_W-1:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	output logic usb_sof_to_timer_trigger_sel_out,
	output logic secondary_spi_pin_route_out,
	output logic secondary_can_pin_route_out,
	output logic adc_regular_trigger_sel_out,
	output logic jtag_debug_port_en_out,
	output logic serial_wire_debug_port_en_out,
	output logic jtag_reset_pin_en_out
);
	import afr_pkg::*;

	localparam int ROUTE_N = 4;
	localparam int ROUTE_POS [ROUTE_N] = '{
		USB_SOF_BIT,
		SPI_ROUTE_BIT,
		CAN_ROUTE_BIT,
		ADC_TRIG_BIT
	};

	logic [RST_STAGES-1:0] rst_sync_ff;
	logic rst_core_n;
	logic wr_hit;
	logic rd_hit;
	logic [DBG_CFG_W-1:0] dbg_code;
	logic usb_sof_ff;
	logic nxt_usb_sof;
	logic spi_route_ff;
	logic nxt_spi_route;
	logic can_route_ff;
	logic nxt_can_route;
	logic adc_trig_ff;
	logic nxt_adc_trig;
	logic [ROUTE_N-1:0] route_vec;
	afr_dbg_e dbg_ff;
	afr_dbg_e nxt_dbg;
	logic jtag_en_ff;
	logic nxt_jtag_en;
	logic sw_en_ff;
	logic nxt_sw_en;
	logic jrst_en_ff;
	logic nxt_jrst_en;
	logic [31:0] rd_word;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;

	// Only one word offset decodes; every other address is ignored by both strobes.
	function automatic logic is_cfg_addr(input logic [ADDR_W-1:0] addr);
		return addr == REMAP_CFG0_OFS;
	endfunction

	// Codes outside the four defined ones keep the current debug setting.
	function automatic afr_dbg_e decode_dbg(
		input logic [DBG_CFG_W-1:0] code,
		input afr_dbg_e cur
	);
		afr_dbg_e res;
		res = cur;
		case (code)
			DBG_FULL: begin
				res = AFR_DBG_FULL;
			end
			DBG_NO_JRST: begin
				res = AFR_DBG_NO_JRST;
			end
			DBG_SW_ONLY: begin
				res = AFR_DBG_SW_ONLY;
			end
			DBG_NONE: begin
				res = AFR_DBG_NONE;
			end
			default: begin
				res = cur;
			end
		endcase
		return res;
	endfunction

	function automatic logic jtag_port_on(input afr_dbg_e st);
		logic on;
		case (st)
			AFR_DBG_FULL: begin
				on = 1'b1;
			end
			AFR_DBG_NO_JRST: begin
				on = 1'b1;
			end
			AFR_DBG_SW_ONLY: begin
				on = 1'b0;
			end
			AFR_DBG_NONE: begin
				on = 1'b0;
			end
			default: begin
				on = 1'b1;
			end
		endcase
		return on;
	endfunction

	function automatic logic sw_port_on(input afr_dbg_e st);
		logic on;
		case (st)
			AFR_DBG_FULL: begin
				on = 1'b1;
			end
			AFR_DBG_NO_JRST: begin
				on = 1'b1;
			end
			AFR_DBG_SW_ONLY: begin
				on = 1'b1;
			end
			AFR_DBG_NONE: begin
				on = 1'b0;
			end
			default: begin
				on = 1'b1;
			end
		endcase
		return on;
	endfunction

	function automatic logic jtag_rst_on(input afr_dbg_e st);
		logic on;
		case (st)
			AFR_DBG_FULL: begin
				on = 1'b1;
			end
			AFR_DBG_NO_JRST: begin
				on = 1'b0;
			end
			AFR_DBG_SW_ONLY: begin
				on = 1'b0;
			end
			AFR_DBG_NONE: begin
				on = 1'b0;
			end
			default: begin
				on = 1'b1;
			end
		endcase
		return on;
	endfunction

	// The debug field is not returned and reserved bits have no storage, so they read back as zero.
	function automatic logic [31:0] readback_word(input logic [ROUTE_N-1:0] route);
		logic [31:0] word;
		word = 32'h0000_0000;
		for (int i = 0; i < ROUTE_N; i++) begin
			word[ROUTE_POS[i]] = route[i];
		end
		return word;
	endfunction

	// A single stage would let reset release race the clock edge.
	if (RST_STAGES < 2) begin : g_chk_stages
		$error("RST_STAGES must be two or more");
	end
	for (genvar gi = 0; gi < ROUTE_N; gi++) begin : g_chk_pos
		if (ROUTE_POS[gi] >= DBG_CFG_LSB &&
			ROUTE_POS[gi] < DBG_CFG_LSB + DBG_CFG_W) begin : g_clash
			$error("Route bit overlaps the debug field");
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_sync_ff <= '0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[RST_STAGES-2:0], 1'b1};
		end
	end
	assign rst_core_n = rst_sync_ff[RST_STAGES-1];

	assign wr_hit = wr_in && is_cfg_addr(addr_in);
	assign rd_hit = rd_in && is_cfg_addr(addr_in);
	assign dbg_code = wdata_in[DBG_CFG_LSB +: DBG_CFG_W];

	// Reserved bits are not stored, so a careless write cannot disturb routing.
	always_comb begin
		nxt_usb_sof = usb_sof_ff;
		if (wr_hit) begin
			nxt_usb_sof = wdata_in[USB_SOF_BIT];
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_core_n) begin
		if (!rst_core_n) begin
			usb_sof_ff <= REMAP_CFG0_RST[USB_SOF_BIT];
		end else begin
			usb_sof_ff <= nxt_usb_sof;
		end
	end

	always_comb begin
		nxt_spi_route = spi_route_ff;
		if (wr_hit) begin
			nxt_spi_route = wdata_in[SPI_ROUTE_BIT];
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_core_n) begin
		if (!rst_core_n) begin
			spi_route_ff <= REMAP_CFG0_RST[SPI_ROUTE_BIT];
		end else begin
			spi_route_ff <= nxt_spi_route;
		end
	end

	always_comb begin
		nxt_can_route = can_route_ff;
		if (wr_hit) begin
			nxt_can_route = wdata_in[CAN_ROUTE_BIT];
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_core_n) begin
		if (!rst_core_n) begin
			can_route_ff <= REMAP_CFG0_RST[CAN_ROUTE_BIT];
		end else begin
			can_route_ff <= nxt_can_route;
		end
	end

	always_comb begin
		nxt_adc_trig = adc_trig_ff;
		if (wr_hit) begin
			nxt_adc_trig = wdata_in[ADC_TRIG_BIT];
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_core_n) begin
		if (!rst_core_n) begin
			adc_trig_ff <= REMAP_CFG0_RST[ADC_TRIG_BIT];
		end else begin
			adc_trig_ff <= nxt_adc_trig;
		end
	end

	always_comb begin
		nxt_dbg = dbg_ff;
		nxt_jtag_en = jtag_en_ff;
		nxt_sw_en = sw_en_ff;
		nxt_jrst_en = jrst_en_ff;
		if (wr_hit) begin
			nxt_dbg = decode_dbg(dbg_code, dbg_ff);
			nxt_jtag_en = jtag_port_on(nxt_dbg);
			nxt_sw_en = sw_port_on(nxt_dbg);
			nxt_jrst_en = jtag_rst_on(nxt_dbg);
		end
	end

	// The enables get flops of their own so the debug pins never see a decode glitch.
	always_ff @(posedge core_clk_in or negedge rst_core_n) begin
		if (!rst_core_n) begin
			dbg_ff <= AFR_DBG_FULL;
			jtag_en_ff <= DBG_EN_RST[2];
			sw_en_ff <= DBG_EN_RST[1];
			jrst_en_ff <= DBG_EN_RST[0];
		end else begin
			dbg_ff <= nxt_dbg;
			jtag_en_ff <= nxt_jtag_en;
			sw_en_ff <= nxt_sw_en;
			jrst_en_ff <= nxt_jrst_en;
		end
	end

	assign route_vec = {adc_trig_ff, can_route_ff, spi_route_ff, usb_sof_ff};

	// Read data stand in the cycle after each read hit and are zero otherwise.
	always_comb begin
		rd_word = readback_word(route_vec);
		nxt_rdata = 32'h0000_0000;
		if (rd_hit) begin
			nxt_rdata = rd_word;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_core_n) begin
		if (!rst_core_n) begin
			rdata_ff <= 32'h0000_0000;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign rdata_out = rdata_ff;
	assign usb_sof_to_timer_trigger_sel_out = usb_sof_ff;
	assign secondary_spi_pin_route_out = spi_route_ff;
	assign secondary_can_pin_route_out = can_route_ff;
	assign adc_regular_trigger_sel_out = adc_trig_ff;
	assign jtag_debug_port_en_out = jtag_en_ff;
	assign serial_wire_debug_port_en_out = sw_en_ff;
	assign jtag_reset_pin_en_out = jrst_en_ff;
endmodule

// ==== tb/afr_pin_model.sv ====
`timescale 1ns/1ps
module afr_pin_model (
	input wire logic spi_in,
	input wire logic can_in,
	output logic [15:0] pin_out
);
	assign pin_out = {spi_in ? 8'hCA : 8'hB3, can_in ? 8'hB5 : 8'hBC};
endmodule

// ==== tb/afr_remap_cfg_sva.sv ====
`timescale 1ns/1ps
module afr_remap_cfg_chk (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic [31:0] rdata_out,
	input wire logic usb_sof_to_timer_trigger_sel_out,
	input wire logic secondary_spi_pin_route_out,
	input wire logic secondary_can_pin_route_out,
	input wire logic adc_regular_trigger_sel_out,
	input wire logic jtag_debug_port_en_out,
	input wire logic serial_wire_debug_port_en_out,
	input wire logic jtag_reset_pin_en_out
);
	wire [2:0] f = {usb_sof_to_timer_trigger_sel_out, secondary_can_pin_route_out,
		adc_regular_trigger_sel_out};
	wire w = wr_in && addr_in == 8'h04, r = rd_in && addr_in == 8'h04;
	wire [2:0] c = wdata_in[26:24];
	wire [3:0] e = {secondary_spi_pin_route_out, jtag_debug_port_en_out,
		serial_wire_debug_port_en_out, jtag_reset_pin_en_out};
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	AST_SPI: assert property (w |=> e[3] == $past(wdata_in[28])) else $error("bad");
	AST_HOLD: assert property (!w |=> $stable(e)) else $error("bad");
	AST_D0: assert property (w && c == 3'h0 |=> e[2:0] == 3'h7) else $error("bad");
	AST_D1: assert property (w && c == 3'h1 |=> e[2:0] == 3'h6) else $error("bad");
	AST_D2: assert property (w && c == 3'h2 |=> e[2:0] == 3'h2) else $error("bad");
	AST_D4: assert property (w && c == 3'h4 |=> e[2:0] == 3'h0) else $error("bad");
	AST_DX: assert property (w && $countones(c) > 1 |=> $stable(e[2:0])) else $error("bad");
	AST_RD: assert property (r |=> rdata_out[28:23] == {e[3], 5'h0}) else $error("bad");
	AST_USB: assert property (w |=> f[2] == $past(wdata_in[29])) else $error("bad usb");
	AST_CAN: assert property (w |=> f[1] == $past(wdata_in[22])) else $error("bad can");
	AST_ADC: assert property (w |=> f[0] == $past(wdata_in[20])) else $error("bad adc");
	AST_HOLDF: assert property (!w |=> $stable(f)) else $error("bad hold");
	AST_RDZ: assert property (!r |=> rdata_out == 32'h0) else $error("bad idle read");
endmodule
bind afr_remap_cfg afr_remap_cfg_chk i_afr_remap_cfg_chk (.*);

// ==== tb/tb_afr_remap_cfg.sv ====
`timescale 1ns/1ps
module tb_afr_remap_cfg;
	logic core_clk_in = 1'h0, rst_n_in = 1'h0, wr_in = 1'h0, rd_in = 1'h0;
	logic [7:0] addr_in = 8'h0;
	logic [31:0] wdata_in = 32'h0, rdata_out;
	logic [22:0] v;
	int miscompares = 0, n_checks = 0, cyc = 0;
	logic [62:0] t [10] = '{{8'h04, 32'h21000000, 23'h59DE46}, {8'h04, 32'h12000000, 23'h655E22},
		{8'h04, 32'h04500000, 23'h59DA98}, {8'h04, 32'h07000000, 23'h59DE00},
		{8'h04, 32'h0, 23'h59DE07}, {8'h08, 32'h30500000, 23'h59DE07},
		{8'h04, 32'h03000000, 23'h59DE07}, {8'h04, 32'h02000000, 23'h59DE02},
		{8'h04, 32'h05000000, 23'h59DE02}, {8'h04, 32'h06000000, 23'h59DE02}};
	afr_remap_cfg i_afr_remap_cfg (.*, .usb_sof_to_timer_trigger_sel_out(v[6]),
		.secondary_spi_pin_route_out(v[5]), .secondary_can_pin_route_out(v[4]),
		.adc_regular_trigger_sel_out(v[3]), .jtag_debug_port_en_out(v[2]),
		.serial_wire_debug_port_en_out(v[1]), .jtag_reset_pin_en_out(v[0]));
	afr_pin_model i_afr_pin_model (.spi_in(v[5]), .can_in(v[4]), .pin_out(v[22:7]));
	always #12.5 core_clk_in = ~core_clk_in;
	always @(posedge core_clk_in) if (++cyc > 300) test_done(1);
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x) $display("[ERR] %0t %h %h", $time, g, x);
		miscompares += int'(g !== x);
	endtask
	task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_in) {addr_in, wdata_in, wr_in, rd_in} <= {a, d, w, !w};
		@(posedge core_clk_in) {wr_in, rd_in} <= 2'h0;
		#1;
	endtask
	task automatic test_done(input int bad);
		miscompares += bad;
		if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge core_clk_in);
		rst_n_in <= 1'h1;
		repeat (3) @(posedge core_clk_in);
		#1 chk({9'h0, v}, 32'h0059DE07);
		foreach (t[i]) begin
			op(1'h1, t[i][62:55], t[i][54:23]);
			chk({9'h0, v}, {9'h0, t[i][22:0]});
			op(1'h0, t[i][62:55], 32'h0);
			chk(rdata_out, t[i][62:55] == 8'h04 ? t[i][54:23] & 32'h30500000 : 32'h0);
		end
		op(1'h1, 8'h04, 32'h34500000);
		chk({9'h0, v}, 32'h00655AF8);
		@(posedge core_clk_in) rst_n_in <= 1'h0;
		op(1'h1, 8'h04, 32'h34500000);
		chk({9'h0, v}, 32'h0059DE07);
		@(posedge core_clk_in) rst_n_in <= 1'h1;
		repeat (2) @(posedge core_clk_in);
		#1 chk({9'h0, v}, 32'h0059DE07);
		op(1'h0, 8'h04, 32'h0);
		chk(rdata_out, 32'h0);
		test_done(0);
	end
endmodule
